// ---- design/bclu_consts.vh ----
`ifndef BCLU_CONSTS_VH
`define BCLU_CONSTS_VH
// ============================================================
// opcodes of the contact forms handled here
`define BCLU_OP_LOAD            3'h0
`define BCLU_OP_LOAD_INV        3'h1
`define BCLU_OP_LOAD_BIT        3'h2
`define BCLU_OP_LOAD_INV_BIT    3'h3
`define BCLU_OP_PAR             3'h4
`define BCLU_OP_PAR_INV         3'h5
`define BCLU_OP_PAR_BIT         3'h6
`define BCLU_OP_PAR_INV_BIT     3'h7
// ============================================================
// operand spaces
`define BCLU_SPACE_IMAGE        2'h0
`define BCLU_SPACE_TIMER        2'h1
`define BCLU_SPACE_COUNTER      2'h2
`define BCLU_SPACE_SPECIAL      2'h3
// ============================================================
// stack geometry
`define BCLU_STACK_DEPTH        8
`define BCLU_LEVEL_W            4
`define BCLU_STACK_FULL         4'h8
// ============================================================
// bit index limit (bcd 0 to 15)
`define BCLU_BIT_MAX            5'h0f
// ============================================================
// timer contact top address per model class (octal 77/177/377/377)
`define BCLU_TMR_MAX0           11'h03f
`define BCLU_TMR_MAX1           11'h07f
`define BCLU_TMR_MAX2           11'h0ff
`define BCLU_TMR_MAX3           11'h0ff
// counter contact top (octal 77/177/177/377)
`define BCLU_CNT_MAX0           11'h03f
`define BCLU_CNT_MAX1           11'h07f
`define BCLU_CNT_MAX2           11'h07f
`define BCLU_CNT_MAX3           11'h0ff
// special relay windows: octal 0-117, 540-577 / 0-137, 540-617
`define BCLU_SP_LO_TOP0         11'h04f
`define BCLU_SP_HI_BOT0         11'h160
`define BCLU_SP_HI_TOP0         11'h17f
`define BCLU_SP_LO_TOP1         11'h05f
`define BCLU_SP_HI_BOT1         11'h160
`define BCLU_SP_HI_TOP1         11'h18f
`endif

// ---- design/bclu_stack.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bclu_consts.vh"
// ============================================================
// eight-level boolean stack, entries shift down on push
module bclu_stack
(
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // control
  input  wire       push_i,
  input  wire       wr_top_i,
  input  wire       clear_i,
  input  wire       din_i,
  // contents
  output wire [7:0] data_o
);
  reg [7:0] ent;
  genvar g;
  generate
    for (g = 0; g < `BCLU_STACK_DEPTH; g = g + 1)
    begin : g_lvl
      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          ent[g] <= 1'b0;
        // a start that also loads leaves only the new value on the stack
        else if (clear_i)
          ent[g] <= (g == 0) ? (push_i & din_i) : 1'b0;
        else if (push_i)
          ent[g] <= (g == 0) ? din_i : ent[(g == 0) ? 0 : g - 1];
        else if (wr_top_i && g == 0)
          ent[g] <= din_i;
      end
    end
  endgenerate
  assign data_o = ent;
endmodule // bclu_stack
`default_nettype wire

// ---- design/bclu_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bclu_consts.vh"
// How it works
// - a normal load pushes the operand's current state unchanged.
// - an inverted load pushes the complement of the operand's state.
// - a bit load pushes one data word bit, the index limited to 0 to 15.
// - an inverted bit load pushes the complement of the selected bit.
// - a parallel join ors the operand state into the current logic.
// - an inverted parallel join ors the operand complement into it.
// - a bit parallel join ors the selected word bit, index 0 to 15.
// - an inverted bit parallel join ors the selected bit's complement.
// - timer contacts accept octal 77, 177, 377, 377 per model class.
// - counter contacts accept octal 77, 177, 177, 377 per model class.
// - special relays accept 0-117,540-577 or 0-137,540-617 in classes 0 and 1; classes 2 and 3 accept any address.
// - evaluation uses an eight-level stack, loads push entries down.
// - a rung needing more than eight levels raises an error.
module bclu_unit
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // instruction
  input  wire        instr_valid_i,
  input  wire [2:0]  opcode_i,
  input  wire [1:0]  space_i,
  input  wire [10:0] addr_i,
  input  wire [7:0]  bit_bcd_i,
  input  wire [1:0]  model_class_i,
  input  wire        rung_start_i,
  // operand data from image register / data memory
  input  wire        point_i,
  input  wire [15:0] word_i,
  // results
  output reg         done_o,
  output reg         top_o,
  output reg  [3:0]  level_o,
  output reg         overflow_err_o,
  output reg         addr_err_o,
  output reg         bit_err_o,
  output wire [7:0]  stack_o
);
  // ============================================================
  // reset release
  reg rst_s1;
  reg rst_s2;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  // ============================================================
  // operand decoding
  wire        is_bit  = opcode_i[1];
  wire        is_inv  = opcode_i[0];
  wire        is_par  = opcode_i[2];
  // bcd index: tens digit may be 0 or 1 only, ones digit 0-9
  wire [4:0]  bit_bin = {1'b0, bit_bcd_i[7:4] == 4'h1, 3'h0}
                        + {1'b0, bit_bcd_i[7:4] == 4'h1, 1'b0}
                        + {1'b0, bit_bcd_i[3:0]};
  wire        bcd_ok  = (bit_bcd_i[3:0] <= 4'h9) &&
                        (bit_bcd_i[7:4] <= 4'h1) &&
                        (bit_bin <= `BCLU_BIT_MAX);
  reg         addr_ok;
  always @*
  begin
    addr_ok = 1'b1;
    case (space_i)
      `BCLU_SPACE_TIMER:
        case (model_class_i)
          2'h0:    addr_ok = addr_i <= `BCLU_TMR_MAX0;
          2'h1:    addr_ok = addr_i <= `BCLU_TMR_MAX1;
          2'h2:    addr_ok = addr_i <= `BCLU_TMR_MAX2;
          default: addr_ok = addr_i <= `BCLU_TMR_MAX3;
        endcase
      `BCLU_SPACE_COUNTER:
        case (model_class_i)
          2'h0:    addr_ok = addr_i <= `BCLU_CNT_MAX0;
          2'h1:    addr_ok = addr_i <= `BCLU_CNT_MAX1;
          2'h2:    addr_ok = addr_i <= `BCLU_CNT_MAX2;
          default: addr_ok = addr_i <= `BCLU_CNT_MAX3;
        endcase
      `BCLU_SPACE_SPECIAL:
        case (model_class_i)
          2'h0:    addr_ok = (addr_i <= `BCLU_SP_LO_TOP0) ||
                             ((addr_i >= `BCLU_SP_HI_BOT0) &&
                              (addr_i <= `BCLU_SP_HI_TOP0));
          2'h1:    addr_ok = (addr_i <= `BCLU_SP_LO_TOP1) ||
                             ((addr_i >= `BCLU_SP_HI_BOT1) &&
                              (addr_i <= `BCLU_SP_HI_TOP1));
          // larger classes' windows lie outside this unit's scope
          default: addr_ok = 1'b1;
        endcase
      default: addr_ok = 1'b1;
    endcase
  end

  // ============================================================
  // contact value
  wire raw_val  = is_bit ? word_i[bit_bin[3:0]] : point_i;
  wire cont_val = raw_val ^ is_inv;
  wire [7:0] stk;
  wire top_cur  = stk[0];
  reg  [3:0] level;
  wire start    = instr_valid_i && rung_start_i;
  wire legal    = instr_valid_i && addr_ok && (!is_bit || bcd_ok);
  wire ovf      = !is_par && (level == `BCLU_STACK_FULL) && !rung_start_i;
  wire do_push  = legal && !is_par && !ovf;
  // joins with an empty stack have nothing to or into, so are refused
  wire do_join  = legal && is_par && (level != 4'h0) && !rung_start_i;
  wire next_din = is_par ? (top_cur | cont_val) : cont_val;

  // a rung start clears the stack in the same cycle as its first load
  bclu_stack u_stack
  (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .push_i   (do_push),
    .wr_top_i (do_join),
    .clear_i  (start),
    .din_i    (next_din),
    .data_o   (stk)
  );
  assign stack_o = stk;

  // ============================================================
  // depth, flags and results
  reg [3:0] next_level;
  always @*
  begin
    next_level = level;
    if (start)
      next_level = do_push ? 4'h1 : 4'h0;
    else if (do_push)
      next_level = level + 4'h1;
  end

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level          <= 4'h0;
      done_o         <= 1'b0;
      top_o          <= 1'b0;
      level_o        <= 4'h0;
      overflow_err_o <= 1'b0;
      addr_err_o     <= 1'b0;
      bit_err_o      <= 1'b0;
    end
    else
    begin
      level   <= next_level;
      level_o <= next_level;
      done_o  <= instr_valid_i;
      if (do_push || do_join)
        top_o <= next_din;
      else if (start)
        top_o <= 1'b0;
      // errors hold until the next rung start; a new error wins
      if (instr_valid_i && ovf)
        overflow_err_o <= 1'b1;
      else if (start)
        overflow_err_o <= 1'b0;
      if (instr_valid_i && !addr_ok)
        addr_err_o <= 1'b1;
      else if (start)
        addr_err_o <= 1'b0;
      if (instr_valid_i && is_bit && !bcd_ok)
        bit_err_o <= 1'b1;
      else if (start)
        bit_err_o <= 1'b0;
    end
  end
endmodule // bclu_unit
`default_nettype wire

// ---- tb/bclu_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bclu_consts.vh"
// ====================
// port checks of the contact unit
module bclu_chk
(
  // inputs of the unit
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        instr_valid_i,
  input wire logic [2:0]  opcode_i,
  input wire logic [1:0]  space_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0]  bit_bcd_i,
  input wire logic        rung_start_i,
  input wire logic        point_i,
  input wire logic [15:0] word_i,
  // outputs of the unit
  input wire logic        done_o,
  input wire logic        top_o,
  input wire logic [3:0]  level_o,
  input wire logic        overflow_err_o,
  input wire logic        addr_err_o,
  input wire logic        bit_err_o,
  input wire logic [7:0]  stack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // image space carries no range check, so these never refuse
  wire img = instr_valid_i && space_i == `BCLU_SPACE_IMAGE;
  wire ld = img && opcode_i[2:1] == 2'h0;
  property p_done; done_o == $past(instr_valid_i); endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_load; ld && rung_start_i |=>
    top_o == ($past(point_i) ^ $past(opcode_i[0])) && level_o == 4'h1;
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_push; ld && !rung_start_i && level_o < 4'h8 |=>
    level_o == $past(level_o) + 4'h1 && stack_o[7:1] == $past(stack_o[6:0]);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_ovf; ld && !rung_start_i && level_o == 4'h8 |=>
    overflow_err_o && $stable(stack_o) && level_o == 4'h8;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_join; img && opcode_i[2:1] == 2'h2 && !rung_start_i &&
    level_o != 4'h0 |=> level_o == $past(level_o) &&
    top_o == ($past(top_o) | ($past(point_i) ^ $past(opcode_i[0])));
  endproperty
  a_join: assert property (p_join) else $error("join wrong");
  property p_bit; img && opcode_i[2:1] == 2'h1 && rung_start_i &&
    bit_bcd_i == 8'h15 |=> top_o == ($past(word_i[15]) ^ $past(opcode_i[0]));
  endproperty
  a_bit: assert property (p_bit) else $error("bit load wrong");
  property p_tmr; instr_valid_i && space_i == `BCLU_SPACE_TIMER &&
    addr_i > 11'h0ff |=> addr_err_o;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer range");
  property p_bcd; instr_valid_i && opcode_i[1] && bit_bcd_i[3:0] > 4'h9
    |=> bit_err_o;
  endproperty
  a_bcd: assert property (p_bcd) else $error("bcd accepted");
  c_ovf: cover property (overflow_err_o);
  c_full: cover property (level_o == 4'h8);
  c_aerr: cover property (addr_err_o);
endmodule // bclu_chk
bind bclu_unit bclu_chk bclu_chk_i (.*);
`default_nettype wire

// ---- tb/bclu_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bclu_consts.vh"
module bclu_unit_tb_top;
  logic        clk_i = 0, rst_n_i = 0, v = 0, rs = 0, pt = 0;
  logic [2:0]  op = 0;
  logic [1:0]  sp = 0, cl = 0;
  logic [10:0] ad = 0;
  logic [7:0]  bcd = 0;
  logic [15:0] wd = 0;
  wire         done, top, ovf, aer, ber;
  wire  [3:0]  lvl;
  wire  [7:0]  stk;
  int          bad_count = 0, checked = 0, cyc = 0;
  logic [10:0] tops [8] = '{11'h03f, 11'h07f, 11'h0ff, 11'h0ff,
                           11'h03f, 11'h07f, 11'h07f, 11'h0ff};
  // {class, error expected, address}
  logic [13:0] sprl [9] = '{{3'h0, 11'h04f}, {3'h1, 11'h050},
    {3'h0, 11'h160}, {3'h0, 11'h17f}, {3'h1, 11'h180}, {3'h2, 11'h05f},
    {3'h3, 11'h060}, {3'h2, 11'h18f}, {3'h3, 11'h190}};
  bclu_unit bclu_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(v), .opcode_i(op), .space_i(sp), .addr_i(ad),
    .bit_bcd_i(bcd), .model_class_i(cl), .rung_start_i(rs), .point_i(pt),
    .word_i(wd), .done_o(done), .top_o(top), .level_o(lvl),
    .overflow_err_o(ovf), .addr_err_o(aer), .bit_err_o(ber), .stack_o(stk));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      test_done();
    end
  end
  task chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // valid stays up so calls run back to back; stop() drops it
  task go(input logic [2:0] o, input logic r, p,
          input logic [1:0] s = 2'h0, input logic [10:0] a = 11'h000,
          input logic [7:0] b = 8'h15);
    {v, op, rs, pt, sp, ad, bcd} = {1'b1, o, r, p, s, a, b};
    @(posedge clk_i);
    #1;
  endtask
  task stop;
    v = 0;
    @(posedge clk_i);
    #1;
  endtask
  task t_load;
    for (int k = 0; k < 8; k++)
    begin
      wd = k[0] ? 16'h8000 : 16'h7fff;
      go(k[2:1], 1'b1, k[0]);
      chk({done, lvl, top}, {1'b1, 4'h1, k[0] ^ k[1]});
    end
    stop();
    chk(done, 16'h0);
  endtask
  task t_join;
    for (int k = 0; k < 16; k++)
    begin
      wd = {k[2], 15'h0};
      go(3'h0, 1'b1, k[3]);
      go({1'b1, k[1:0]}, 1'b0, k[2]);
      chk({lvl, top}, {4'h1, k[3] | (k[2] ^ k[0])});
    end
    stop();
  endtask
  task t_stack;
    go(3'h0, 1'b1, 1'b1);
    for (int k = 2; k < 9; k++)
    begin
      go(3'h0, 1'b0, k[0]);
      chk(lvl, k[15:0]);
    end
    chk(stk, 16'h00aa);
    go(3'h0, 1'b0, 1'b1);
    chk({ovf, lvl, stk}, {1'b1, 4'h8, 8'haa});
    go(3'h1, 1'b1, 1'b1);
    chk({ovf, lvl, top, stk}, {1'b0, 4'h1, 1'b0, 8'h00});
    stop();
  endtask
  task t_range;
    for (int k = 0; k < 8; k++)
    begin
      cl = k[1:0];
      go(3'h0, 1'b1, 1'b0, {k[2], ~k[2]}, tops[k]);
      chk(aer, 16'h0);
      go(3'h0, 1'b1, 1'b0, {k[2], ~k[2]}, tops[k] + 11'h001);
      chk(aer, 16'h1);
    end
    for (int k = 0; k < 9; k++)
    begin
      cl = sprl[k][13:12];
      go(3'h0, 1'b1, 1'b0, 2'h3, sprl[k][10:0]);
      chk(aer, sprl[k][11]);
    end
    go(3'h2, 1'b1, 1'b0, 2'h0, 11'h000, 8'h1a);
    chk(ber, 16'h1);
    go(3'h6, 1'b1, 1'b0, 2'h0, 11'h000, 8'h20);
    chk(ber, 16'h1);
    go(3'h2, 1'b1, 1'b0, 2'h0, 11'h000, 8'h00);
    chk(ber, 16'h0);
    stop();
  endtask
  task test_done;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1;
    repeat (3) @(posedge clk_i);
    #1;
    t_load();
    t_join();
    t_stack();
    t_range();
    test_done();
  end
endmodule // bclu_unit_tb_top
`default_nettype wire
